// *** hdl/mptc_codec.sv ***
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module mptc_codec import mptc_pkg::*; #(
  parameter logic [47:0] OWN_MAC = 48'h020000000001
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // AHB-Lite slave.
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Management link.
  input wire logic link_clk_i,
  input wire logic link_rxd_i,
  input wire logic link_rxdv_i,
  output logic link_txd_o,
  output logic link_txen_o,
  // Frames from the switch toward the CPU.
  input wire logic eg_valid_i,
  input wire logic [7:0] eg_data_i,
  input wire logic eg_last_i,
  input wire mptc_eg_meta_t eg_meta_i,
  output logic eg_ready_o,
  output logic eg_redirect_o,
  // Frames from the CPU into the switch.
  output logic ing_valid_o,
  output logic [7:0] ing_data_o,
  output logic ing_end_o,
  output logic ing_hdr_vld_o,
  output mptc_ing_hdr_t ing_hdr_o,
  // Buffer congestion from the switch core.
  input wire logic xoff_i
);

  function automatic logic [7:0] pause_byte(input logic [4:0] idx,
                                            input logic [15:0] q);
    logic [159:0] f;
    f = {MPTC_PAUSE_DA, OWN_MAC, MPTC_PAUSE_TYPE, MPTC_PAUSE_OPC, q, 16'h0};
    return f[159 - 8 * int'(idx) -: 8];
  endfunction

  function automatic logic [63:0] mk_hdr(input mptc_eg_meta_t m);
    mptc_hdr_cause_t c;
    mptc_hdr_stamp_t s;
    c.op = m.op;
    c.rsvd = '0;
    c.class_id = m.class_valid ? m.class_id : 8'h00;
    c.cause = m.cause & MPTC_CAUSE_MASK;
    c.tc = m.tc;
    c.port = m.in_port;
    s.op = m.op;
    s.rsvd = '0;
    s.tx = m.stamp_tx;
    s.port = m.stamp_port;
    s.stamp = m.stamp;
    return (m.op == MPTC_OP_STAMP) ? s : {c, 32'h0};
  endfunction

  logic [2:0] lclk_q;
  logic [1:0] rxd_q;
  logic [1:0] dv_q;
  logic dv_prev_q;
  logic rise, fall, endf;
  mptc_state_t st_q;
  logic [2:0] bit_q;
  logic [7:0] cur_q;
  logic [63:0] hdr_q;
  logic [3:0] hcnt_q;
  logic [4:0] pidx_q;
  logic [15:0] pq_q;
  logic txd_q, txen_q, redir_q;
  logic [7:0] hold_q;
  logic hold_full_q, lastin_q, eg_ready_q;
  logic fire, take, fwd_ok, to_p5, start;
  logic pgen_q, xoff_prev_q;
  logic [15:0] pend_q;
  logic [24:0] pcnt_q;
  logic [2:0] rbit_q;
  logic [7:0] rbyte_q, nb;
  logic [4:0] ridx_q;
  logic [31:0] hdrw_q;
  logic pm_q, bdone;
  logic [15:0] rq_q;
  logic ing_valid_q, ing_end_q, ing_hdr_vld_q;
  logic [7:0] ing_data_q;
  mptc_ing_hdr_t ing_hdr_q;
  mptc_hdr_in_t hin;
  logic [2:0] ctrl_q;
  logic [15:0] quanta_q;
  logic [15:0] txcnt_q, rxcnt_q, dropcnt_q;
  logic wr_q, rd_q, hready_q;
  logic [7:0] a_q;
  logic [31:0] hrdata_q, rdmux;
  logic ap;
  logic [7:0] pbyte;

  assign pbyte = pause_byte(pidx_q, pq_q);

  // Link clock and receive pins are resynchronised before use.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lclk_q <= '0;
      rxd_q <= '0;
      dv_q <= '0;
      dv_prev_q <= 1'b0;
    end else begin
      lclk_q <= {lclk_q[1:0], link_clk_i};
      rxd_q <= {rxd_q[0], link_rxd_i};
      dv_q <= {dv_q[0], link_rxdv_i};
      dv_prev_q <= dv_q[1];
    end
  end

  assign rise = lclk_q[1] & ~lclk_q[2];
  assign fall = ~lclk_q[1] & lclk_q[2];
  assign endf = dv_prev_q & ~dv_q[1];
  assign fire = eg_valid_i & eg_ready_q;
  assign take = fall & (bit_q == 3'h0) & (st_q == MPTC_BODY) & hold_full_q;
  assign fwd_ok = ctrl_q[MPTC_CTRL_FWD] |
                  eg_meta_i.cause[MPTC_CAUSE_MIRROR];
  assign to_p5 = ctrl_q[MPTC_CTRL_DUAL] & eg_meta_i.from_wan;
  assign start = fall & (st_q == MPTC_IDLE) & ~pgen_q & eg_valid_i &
                 (pcnt_q == '0) & fwd_ok & ~to_p5;

  // Transmit sequencer; data frames wait on receive only while a received pause is obeyed, never on other receive activity.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= MPTC_IDLE;
      bit_q <= '0;
      cur_q <= '0;
      hdr_q <= '0;
      hcnt_q <= '0;
      pidx_q <= '0;
      pq_q <= '0;
      txd_q <= 1'b0;
      txen_q <= 1'b0;
      redir_q <= 1'b0;
    end else begin
      redir_q <= 1'b0;
      if (st_q == MPTC_DROP) begin
        if (fire && eg_last_i) begin
          st_q <= MPTC_IDLE;
        end
      end else if (fall && bit_q != 3'h0) begin
        txd_q <= cur_q[bit_q];
        bit_q <= 3'(bit_q + 3'h1);
      end else if (fall) begin
        unique case (st_q)
          MPTC_IDLE: begin
            txen_q <= 1'b0;
            if (pgen_q) begin
              st_q <= MPTC_PTX;
              pidx_q <= '0;
              pq_q <= pend_q;
            end else if (eg_valid_i && pcnt_q == '0) begin
              if (fwd_ok && !to_p5) begin
                st_q <= MPTC_HDR;
                hdr_q <= mk_hdr(eg_meta_i);
                hcnt_q <= (eg_meta_i.op == MPTC_OP_STAMP) ?
                          MPTC_HDR_LONG : MPTC_HDR_SHORT;
              end else begin
                st_q <= MPTC_DROP;
                redir_q <= to_p5;
              end
            end
          end
          MPTC_HDR: begin
            cur_q <= hdr_q[63:56];
            txd_q <= hdr_q[56];
            txen_q <= 1'b1;
            bit_q <= 3'h1;
            hdr_q <= {hdr_q[55:0], 8'h00};
            hcnt_q <= 4'(hcnt_q - 4'h1);
            if (hcnt_q == 4'h1) begin
              st_q <= MPTC_BODY;
            end
          end
          MPTC_BODY: begin
            if (hold_full_q) begin
              cur_q <= hold_q;
              txd_q <= hold_q[0];
              bit_q <= 3'h1;
            end else if (lastin_q) begin
              txen_q <= 1'b0;
              st_q <= MPTC_IDLE;
            end
          end
          MPTC_PTX: begin
            if (pidx_q == MPTC_PAUSE_LEN) begin
              txen_q <= 1'b0;
              st_q <= MPTC_IDLE;
            end else begin
              cur_q <= pbyte;
              txd_q <= pbyte[0];
              txen_q <= 1'b1;
              bit_q <= 3'h1;
              pidx_q <= 5'(pidx_q + 5'h01);
            end
          end
          default: st_q <= MPTC_IDLE;
        endcase
      end
    end
  end

  // One-octet holding stage between the core stream and the serialiser.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_q <= '0;
      hold_full_q <= 1'b0;
      lastin_q <= 1'b0;
      eg_ready_q <= 1'b0;
    end else begin
      if (fire && st_q != MPTC_DROP) begin
        hold_q <= eg_data_i;
        hold_full_q <= 1'b1;
      end else if (take) begin
        hold_full_q <= 1'b0;
      end
      if (st_q == MPTC_IDLE) begin
        lastin_q <= 1'b0;
      end else if (fire && eg_last_i) begin
        lastin_q <= 1'b1;
      end
      if (st_q == MPTC_DROP) begin
        eg_ready_q <= !(fire && eg_last_i);
      end else begin
        eg_ready_q <= (st_q == MPTC_HDR || st_q == MPTC_BODY) && !lastin_q &&
                      !fire && !hold_full_q;
      end
    end
  end

  // Pause generation on each change of core congestion.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pgen_q <= 1'b0;
      pend_q <= '0;
      xoff_prev_q <= 1'b0;
    end else begin
      xoff_prev_q <= xoff_i;
      if (xoff_i != xoff_prev_q && ctrl_q[MPTC_CTRL_PGEN]) begin
        pgen_q <= 1'b1;
        pend_q <= xoff_i ? quanta_q : 16'h0000;
      end else if (fall && st_q == MPTC_IDLE) begin
        pgen_q <= 1'b0;
      end
    end
  end

  // Pause obedience counted in link bit times.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pcnt_q <= '0;
    end else if (endf && pm_q && ridx_q >= MPTC_PAUSE_MIN) begin
      pcnt_q <= {rq_q, 9'h000} << (MPTC_QUANTUM_SHIFT - 9);
    end else if (rise && pcnt_q != '0) begin
      pcnt_q <= 25'(pcnt_q - 25'h1);
    end
  end

  assign nb = {rxd_q[1], rbyte_q[7:1]};
  assign bdone = rise & dv_q[1] & (rbit_q == 3'h7);
  assign hin = {hdrw_q[23:0], nb};

  // Receive deserialiser, pause recogniser and header parser.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rbit_q <= '0;
      rbyte_q <= '0;
      ridx_q <= '0;
      hdrw_q <= '0;
      pm_q <= 1'b0;
      rq_q <= '0;
    end else if (endf) begin
      rbit_q <= '0;
      ridx_q <= '0;
    end else if (rise && dv_q[1]) begin
      rbyte_q <= nb;
      rbit_q <= 3'(rbit_q + 3'h1);
      if (bdone) begin
        ridx_q <= (ridx_q == 5'h1F) ? ridx_q : 5'(ridx_q + 5'h01);
        if (ridx_q < MPTC_HDR_RX) begin
          hdrw_q <= hin;
        end
        if (ridx_q == 5'h00) begin
          pm_q <= (nb == pause_byte(ridx_q, 16'h0000));
        end else if (ridx_q < 5'h06 || (ridx_q >= 5'h0C && ridx_q < 5'h10)) begin
          pm_q <= pm_q & (nb == pause_byte(ridx_q, 16'h0000));
        end
        // Only the pause-time octets of the frame feed the quanta.
        if (ridx_q == 5'h10 || ridx_q == 5'h11) begin
          rq_q <= {rq_q[7:0], nb};
        end
      end
    end
  end

  // Frames toward the switch lose their header; pause frames end here.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ing_valid_q <= 1'b0;
      ing_data_q <= '0;
      ing_end_q <= 1'b0;
      ing_hdr_vld_q <= 1'b0;
      ing_hdr_q <= '0;
    end else begin
      ing_valid_q <= bdone && ridx_q >= MPTC_HDR_RX && !pm_q;
      ing_end_q <= endf && ridx_q >= MPTC_HDR_RX && !pm_q;
      ing_hdr_vld_q <= bdone && ridx_q == 5'h03 && !pm_q;
      if (bdone) begin
        ing_data_q <= nb;
      end
      if (bdone && ridx_q == 5'h03) begin
        ing_hdr_q.op <= hin.op;
        ing_hdr_q.lookup <= hin.op == MPTC_OP_REASON;
        ing_hdr_q.tc <= hin.tc;
        ing_hdr_q.encap <= mptc_encap_t'(hin.te);
        ing_hdr_q.ts_req <= hin.op == MPTC_OP_STAMP && hin.ts;
        ing_hdr_q.egress_map <= (hin.op == MPTC_OP_STAMP) ?
            {hin.map[MPTC_MAP_MGMT], hin.map[MPTC_MAP_PORTS-1:0]} :
            7'h00;
        ing_hdr_q.err <= hin.op != MPTC_OP_REASON && hin.op != MPTC_OP_STAMP;
      end
    end
  end

  // Frame statistics.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      txcnt_q <= '0;
      rxcnt_q <= '0;
      dropcnt_q <= '0;
    end else begin
      if (start) begin
        txcnt_q <= 16'(txcnt_q + 16'h1);
      end
      if (ing_end_q) begin
        rxcnt_q <= 16'(rxcnt_q + 16'h1);
      end
      if (fall && st_q == MPTC_IDLE && !pgen_q && eg_valid_i &&
          pcnt_q == '0 && !(fwd_ok && !to_p5)) begin
        dropcnt_q <= 16'(dropcnt_q + 16'h1);
      end
    end
  end

  assign ap = hsel_i & hready_i & htrans_i[1];

  always_comb begin
    unique case (a_q)
      MPTC_CTRL_OFS: rdmux = {29'h0, ctrl_q};
      MPTC_QUANTA_OFS: rdmux = {16'h0, quanta_q};
      MPTC_STATUS_OFS: rdmux = {dropcnt_q, 14'h0, txen_q, pcnt_q != '0};
      MPTC_COUNT_OFS: rdmux = {rxcnt_q, txcnt_q};
      default: rdmux = 32'h0;
    endcase
  end

  // Bus slave: writes finish at once, reads take one wait state.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      a_q <= '0;
      hready_q <= 1'b1;
      hrdata_q <= '0;
      ctrl_q <= MPTC_CTRL_RST;
      quanta_q <= MPTC_QUANTA_RST;
    end else begin
      wr_q <= ap & hwrite_i;
      rd_q <= ap & ~hwrite_i;
      hready_q <= !(ap && !hwrite_i);
      if (ap) begin
        a_q <= haddr_i[7:0];
      end
      if (rd_q) begin
        hrdata_q <= rdmux;
      end
      if (wr_q && a_q == MPTC_CTRL_OFS) begin
        ctrl_q <= hwdata_i[2:0];
      end
      if (wr_q && a_q == MPTC_QUANTA_OFS) begin
        quanta_q <= hwdata_i[15:0];
      end
    end
  end

  assign hrdata_o = hrdata_q;
  assign hreadyout_o = hready_q;
  assign hresp_o = 1'b0 & hsize_i[0];
  assign link_txd_o = txd_q;
  assign link_txen_o = txen_q;
  assign eg_ready_o = eg_ready_q;
  assign eg_redirect_o = redir_q;
  assign ing_valid_o = ing_valid_q;
  assign ing_data_o = ing_data_q;
  assign ing_end_o = ing_end_q;
  assign ing_hdr_vld_o = ing_hdr_vld_q;
  assign ing_hdr_o = ing_hdr_q;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_hdr_order;
    fall && bit_q == 3'h0 && st_q == MPTC_HDR |=>
      txd_q == $past(hdr_q[56]) && cur_q == $past(hdr_q[63:56]);
  endproperty
  a_hdr_order: assert property (p_hdr_order)
    else $error("header octet order wrong");
  property p_pause_bare;
    fall && bit_q == 3'h0 && st_q == MPTC_PTX && pidx_q == 5'h00 |=>
      cur_q == MPTC_PAUSE_DA[47:40] && txen_q;
  endproperty
  a_pause_bare: assert property (p_pause_bare)
    else $error("pause frame does not start with its address");
  property p_obey;
    fall && st_q == MPTC_IDLE && pcnt_q != '0 |=> st_q != MPTC_HDR;
  endproperty
  a_obey: assert property (p_obey)
    else $error("frame started while paused");
  property p_class;
    start && eg_meta_i.op == MPTC_OP_REASON && !eg_meta_i.class_valid |=>
      hdr_q[55:48] == 8'h00 && hdr_q[47:46] == 2'h0;
  endproperty
  a_class: assert property (p_class)
    else $error("class or reserved cause bits not zero");
  property p_reason;
    start && eg_meta_i.op == MPTC_OP_REASON |=>
      hdr_q[36:32] == $past(eg_meta_i.in_port) &&
      hdr_q[39:37] == $past(eg_meta_i.tc) && hcnt_q == MPTC_HDR_SHORT;
  endproperty
  a_reason: assert property (p_reason)
    else $error("cause header fields misplaced");
  property p_stamp;
    start && eg_meta_i.op == MPTC_OP_STAMP |=>
      hdr_q[37] == $past(eg_meta_i.stamp_tx) &&
      hdr_q[31:0] == $past(eg_meta_i.stamp) && hcnt_q == MPTC_HDR_LONG;
  endproperty
  a_stamp: assert property (p_stamp)
    else $error("stamp header fields misplaced");
  property p_forward;
    fall && st_q == MPTC_IDLE && !pgen_q && eg_valid_i && pcnt_q == '0 &&
      !ctrl_q[MPTC_CTRL_FWD] && !eg_meta_i.cause[MPTC_CAUSE_MIRROR] |=>
      st_q == MPTC_DROP ##1 eg_ready_o;
  endproperty
  a_forward: assert property (p_forward)
    else $error("unmirrored frame forwarded while disabled");
  property p_dual;
    fall && st_q == MPTC_IDLE && !pgen_q && eg_valid_i && pcnt_q == '0 &&
      ctrl_q[MPTC_CTRL_DUAL] && eg_meta_i.from_wan |=> eg_redirect_o;
  endproperty
  a_dual: assert property (p_dual)
    else $error("wan frame not redirected");
  property p_strip;
    bdone && ridx_q < MPTC_HDR_RX |=> !ing_valid_o;
  endproperty
  a_strip: assert property (p_strip)
    else $error("header octet passed to the switch");
  property p_map;
    ing_hdr_vld_o && ing_hdr_o.op == MPTC_OP_STAMP |->
      ing_hdr_o.egress_map == {hdrw_q[8], hdrw_q[5:0]};
  endproperty
  a_map: assert property (p_map)
    else $error("egress bitmap wrong");
  property p_encap;
    ing_hdr_vld_o |-> ing_hdr_o.encap == mptc_encap_t'(hdrw_q[25:24]);
  endproperty
  a_encap: assert property (p_encap)
    else $error("tag enforcement wrong");

  property p_c_pause_tx;
    st_q == MPTC_PTX && pidx_q == MPTC_PAUSE_LEN;
  endproperty
  c_pause_tx: cover property (p_c_pause_tx);
  property p_c_pause_rx;
    endf && pm_q && ridx_q >= MPTC_PAUSE_MIN;
  endproperty
  c_pause_rx: cover property (p_c_pause_rx);
  property p_c_duplex;
    txen_q && dv_q[1];
  endproperty
  c_duplex: cover property (p_c_duplex);

endmodule // mptc_codec

// *** hdl/mptc_pkg.sv ***
package mptc_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] MPTC_CTRL_OFS = 8'h00;
  localparam logic [7:0] MPTC_QUANTA_OFS = 8'h04;
  localparam logic [7:0] MPTC_STATUS_OFS = 8'h08;
  localparam logic [7:0] MPTC_COUNT_OFS = 8'h0C;

  // Control fields and reset values.
  localparam int MPTC_CTRL_FWD = 0;
  localparam int MPTC_CTRL_DUAL = 1;
  localparam int MPTC_CTRL_PGEN = 2;
  localparam logic [2:0] MPTC_CTRL_RST = 3'h5;
  localparam logic [15:0] MPTC_QUANTA_RST = 16'hFFFF;

  // Opcodes and forward-cause flag positions.
  localparam logic [2:0] MPTC_OP_REASON = 3'h0;
  localparam logic [2:0] MPTC_OP_STAMP = 3'h1;
  localparam int MPTC_CAUSE_MIRROR = 0;
  localparam int MPTC_CAUSE_LEARN = 1;
  localparam int MPTC_CAUSE_SWITCH = 2;
  localparam int MPTC_CAUSE_TERM = 3;
  localparam int MPTC_CAUSE_SNOOP = 4;
  localparam int MPTC_CAUSE_FLOOD = 5;
  localparam logic [7:0] MPTC_CAUSE_MASK = 8'h3F;
  localparam int MPTC_MAP_PORTS = 6;
  localparam int MPTC_MAP_MGMT = 8;

  // Header lengths in octets and pause frame layout.
  localparam logic [3:0] MPTC_HDR_SHORT = 4'h4;
  localparam logic [3:0] MPTC_HDR_LONG = 4'h8;
  localparam logic [4:0] MPTC_HDR_RX = 5'h04;
  localparam logic [47:0] MPTC_PAUSE_DA = 48'h0180C2000001;
  localparam logic [15:0] MPTC_PAUSE_TYPE = 16'h8808;
  localparam logic [15:0] MPTC_PAUSE_OPC = 16'h0001;
  localparam logic [4:0] MPTC_PAUSE_LEN = 5'h14;
  localparam logic [4:0] MPTC_PAUSE_MIN = 5'h12;
  localparam int MPTC_QUANTUM_SHIFT = 9;

  typedef enum logic [2:0] {
    MPTC_IDLE = 3'h0,
    MPTC_HDR = 3'h1,
    MPTC_BODY = 3'h3,
    MPTC_PTX = 3'h2,
    MPTC_DROP = 3'h6
  } mptc_state_t;

  typedef enum logic [1:0] {
    MPTC_ENC_FOLLOW = 2'h0,
    MPTC_ENC_UNTAG = 2'h1,
    MPTC_ENC_TAG = 2'h2,
    MPTC_ENC_RSVD = 2'h3
  } mptc_encap_t;

  typedef struct packed {
    logic [2:0] op;
    logic [4:0] rsvd;
    logic [7:0] class_id;
    logic [7:0] cause;
    logic [2:0] tc;
    logic [4:0] port;
  } mptc_hdr_cause_t;

  typedef struct packed {
    logic [2:0] op;
    logic [22:0] rsvd;
    logic tx;
    logic [4:0] port;
    logic [31:0] stamp;
  } mptc_hdr_stamp_t;

  typedef struct packed {
    logic [2:0] op;
    logic [2:0] tc;
    logic [1:0] te;
    logic ts;
    logic [22:0] map;
  } mptc_hdr_in_t;

  typedef struct packed {
    logic [2:0] op;
    logic class_valid;
    logic [7:0] class_id;
    logic [7:0] cause;
    logic [2:0] tc;
    logic [4:0] in_port;
    logic from_wan;
    logic stamp_tx;
    logic [4:0] stamp_port;
    logic [31:0] stamp;
  } mptc_eg_meta_t;

  typedef struct packed {
    logic [2:0] op;
    logic lookup;
    logic [2:0] tc;
    mptc_encap_t encap;
    logic ts_req;
    logic [6:0] egress_map;
    logic err;
  } mptc_ing_hdr_t;

endpackage

// *** tb/mptc_codec_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin \
  checked++; \
  if ((a) !== (b)) begin \
    mismatches++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, a, b); \
  end \
end
module mptc_codec_tb import mptc_pkg::*;;
  localparam logic [47:0] SA = 48'h02A5A5A5A5A5;
  logic ref_clk, nrst, hsel, hwrite, hready, hresp, link_clk, rxd, rxdv;
  logic txd, txen, eg_valid, eg_last, eg_ready, eg_redir;
  logic ing_valid, ing_end, ing_hvld, xoff;
  logic [31:0] haddr, hwdata, hrdata, rd, h;
  logic [15:0] qv;
  logic [143:0] pv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] eg_data, ing_data;
  logic [7:0] dq[$], pl[$], exp_q[$];
  mptc_eg_meta_t eg_meta, m;
  mptc_ing_hdr_t ing_hdr, eh;
  mptc_ing_hdr_t hq[$];
  int mismatches, checked, redirs, ends;

  mptc_codec #(.OWN_MAC(SA)) u_mptc_codec (.ref_clk_i(ref_clk),
    .nrst_i(nrst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .link_clk_i(link_clk), .link_rxd_i(rxd),
    .link_rxdv_i(rxdv), .link_txd_o(txd), .link_txen_o(txen),
    .eg_valid_i(eg_valid), .eg_data_i(eg_data), .eg_last_i(eg_last),
    .eg_meta_i(eg_meta), .eg_ready_o(eg_ready), .eg_redirect_o(eg_redir),
    .ing_valid_o(ing_valid), .ing_data_o(ing_data), .ing_end_o(ing_end),
    .ing_hdr_vld_o(ing_hvld), .ing_hdr_o(ing_hdr), .xoff_i(xoff));
  mptc_cpu_model u_mptc_cpu_model (.link_clk_i(link_clk),
    .link_txd_i(txd), .link_txen_i(txen), .link_rxd_o(rxd),
    .link_rxdv_o(rxdv));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // The link clock runs free so the transmitter always finds its edges.
  initial begin
    link_clk = 1'b0;
    #7;
    forever #160 link_clk = ~link_clk;
  end
  always @(posedge ref_clk) begin
    if (ing_hvld === 1'b1) hq.push_back(ing_hdr);
    if (ing_valid === 1'b1) dq.push_back(ing_data);
    if (ing_end === 1'b1) ends++;
    if (eg_redir === 1'b1) redirs++;
  end

  task automatic results;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge ref_clk); while (hready !== 1'b1 && ++n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1 && ++n < 50);
    rd = hrdata;
    `CHK(hresp, 1'b0)
    if (n >= 50) mismatches++;
  endtask
  task automatic cmp_q(input logic [7:0] g[$], input logic [7:0] e[$]);
    `CHK(g.size(), e.size())
    foreach (e[i]) `CHK(g[i], e[i])
  endtask
  task automatic wait_tx;
    int n;
    for (n = 0; n < 20000 && txen !== 1'b1; n++) @(posedge ref_clk);
    for (n = n; n < 40000 && txen !== 1'b0; n++) @(posedge ref_clk);
    if (n >= 40000) mismatches++;
    repeat (20) @(posedge ref_clk);
  endtask
  task automatic eg_case(input mptc_eg_meta_t mm, input bit sent);
    logic [63:0] hh;
    int k;
    k = (mm.op == MPTC_OP_STAMP) ? 8 : 4;
    hh = (k == 8) ? {mm.op, 23'h0, mm.stamp_tx, mm.stamp_port, mm.stamp}
      : {mm.op, 5'h0, mm.class_valid ? mm.class_id : 8'h00,
         mm.cause & 8'h3F, mm.tc, mm.in_port, 32'h0};
    exp_q = {};
    for (int i = 0; i < k; i++) exp_q.push_back(hh[63 - 8 * i -: 8]);
    exp_q = {exp_q, pl};
    u_mptc_cpu_model.rx_q = {};
    @(posedge ref_clk);
    eg_meta <= mm;
    foreach (pl[i]) begin
      k = 0;
      eg_valid <= 1'b1;
      eg_data <= pl[i];
      eg_last <= (i == pl.size() - 1);
      do @(posedge ref_clk); while (eg_ready !== 1'b1 && ++k < 5000);
    end
    eg_valid <= 1'b0;
    if (sent) begin
      wait_tx;
      cmp_q(u_mptc_cpu_model.rx_q, exp_q);
    end else begin
      repeat (900) @(posedge ref_clk);
      `CHK(u_mptc_cpu_model.rx_q.size(), 0)
    end
  endtask
  task automatic ing_case(input logic [31:0] hv);
    exp_q = {hv[31:24], hv[23:16], hv[15:8], hv[7:0], pl};
    hq = {};
    dq = {};
    ends = 0;
    u_mptc_cpu_model.send(exp_q);
    repeat (30) @(posedge ref_clk);
    eh = hq[0];
    `CHK(hq.size(), 1)
    `CHK(eh.op, hv[31:29])
    `CHK(eh.lookup, hv[31:29] == 3'h0)
    `CHK(eh.tc, hv[28:26])
    `CHK(eh.encap, hv[25:24])
    if (hv[29]) begin
      `CHK(eh.ts_req, hv[23])
      `CHK(eh.egress_map, {hv[8], hv[5:0]})
    end else begin
      `CHK(eh.egress_map, 7'h00)
    end
    cmp_q(dq, pl);
    `CHK(ends, 1)
  endtask
  task automatic pause_case(input logic x, input logic [15:0] q);
    logic [143:0] v;
    v = {MPTC_PAUSE_DA, SA, MPTC_PAUSE_TYPE, MPTC_PAUSE_OPC, q};
    u_mptc_cpu_model.rx_q = {};
    @(posedge ref_clk);
    xoff <= x;
    wait_tx;
    exp_q = {};
    for (int i = 0; i < 18; i++) exp_q.push_back(v[143 - 8 * i -: 8]);
    `CHK(u_mptc_cpu_model.rx_q.size(), 20)
    u_mptc_cpu_model.rx_q = u_mptc_cpu_model.rx_q[0:17];
    cmp_q(u_mptc_cpu_model.rx_q, exp_q);
  endtask

  initial begin
    #4_000_000;
    mismatches++;
    results;
  end
  initial begin
    {nrst, hsel, hwrite, eg_valid, eg_last, xoff} = '0;
    {haddr, hwdata, htrans, hsize, eg_data, eg_meta} = '0;
    {mismatches, checked, redirs, ends} = '0;
    void'($urandom(32'h03D6567D));
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    ahb(1'b0, MPTC_CTRL_OFS, 32'h0);
    `CHK(rd[2:0], 3'h5)
    ahb(1'b0, MPTC_QUANTA_OFS, 32'h0);
    `CHK(rd[15:0], 16'hFFFF)
    ahb(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0)
    qv = 16'($urandom);
    ahb(1'b1, MPTC_QUANTA_OFS, {16'h0, qv});
    ahb(1'b0, MPTC_QUANTA_OFS, 32'h0);
    `CHK(rd[15:0], qv)
    for (int i = 0; i < 4; i++) begin
      m = mptc_eg_meta_t'(67'({$urandom, $urandom, $urandom}));
      m.op = {2'h0, i[0]};
      m.class_valid = i[1];
      m.from_wan = 1'b0;
      m.cause[0] = 1'b1;
      pl = {8'($urandom), 8'($urandom), 8'($urandom)};
      eg_case(m, 1'b1);
    end
    ahb(1'b1, MPTC_CTRL_OFS, 32'h7);
    m.op = MPTC_OP_REASON;
    m.from_wan = 1'b1;
    redirs = 0;
    eg_case(m, 1'b0);
    `CHK(redirs, 1)
    ahb(1'b1, MPTC_CTRL_OFS, 32'h4);
    m.from_wan = 1'b0;
    m.cause = 8'h04;
    eg_case(m, 1'b0);
    m.cause = 8'h01;
    eg_case(m, 1'b1);
    ahb(1'b1, MPTC_CTRL_OFS, 32'h5);
    for (int i = 0; i < 4; i++) begin
      h = {i[0] ? 3'h1 : 3'h0, 3'(i + 1), 2'(i), 24'h0};
      if (i[0]) h[23:0] = 24'($urandom);
      pl = {8'($urandom), 8'($urandom)};
      ing_case(h);
    end
    pv = {MPTC_PAUSE_DA, SA, MPTC_PAUSE_TYPE, MPTC_PAUSE_OPC, 16'h0001};
    exp_q = {};
    for (int i = 0; i < 18; i++) exp_q.push_back(pv[143 - 8 * i -: 8]);
    hq = {};
    dq = {};
    ends = 0;
    u_mptc_cpu_model.send(exp_q);
    repeat (30) @(posedge ref_clk);
    `CHK(hq.size() + dq.size() + ends, 0)
    ahb(1'b0, MPTC_STATUS_OFS, 32'h0);
    `CHK(rd[0], 1'b1)
    pause_case(1'b1, qv);
    pause_case(1'b0, 16'h0000);
    results;
  end
endmodule // mptc_codec_tb

// *** tb/mptc_cpu_model.sv ***
`timescale 1ns/1ps
module mptc_cpu_model (
  // Link towards the block.
  input wire logic link_clk_i,
  input wire logic link_txd_i,
  input wire logic link_txen_i,
  output logic link_rxd_o,
  output logic link_rxdv_o
);
  logic [7:0] rx_q[$];
  logic [7:0] sh_q;
  int n;
  initial begin
    link_rxd_o = 1'b0;
    link_rxdv_o = 1'b0;
    n = 0;
  end
  always @(posedge link_clk_i) begin
    if (link_txen_i) begin
      sh_q = {link_txd_i, sh_q[7:1]};
      n = (n + 1) % 8;
      if (n == 0) rx_q.push_back(sh_q);
    end else n = 0;
  end
  // Callers hand whole frames, header first; pause frames carry none.
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      for (int b = 0; b < 8; b++) begin
        @(negedge link_clk_i);
        link_rxdv_o = 1'b1;
        link_rxd_o = f[i][b];
      end
    end
    @(negedge link_clk_i);
    link_rxdv_o = 1'b0;
    link_rxd_o = ~link_rxd_o;
  endtask
endmodule // mptc_cpu_model
